// >>> pbs_burst_sram.sv
// pipelined burst synchronous memory: control, burst counter and array
//
// Overview of operation
// - all synchronous pins sampled on the rising clock edge only
// - address registered only with all selects active and a strobe low
// - master select gates the processor strobe; controller strobe unaffected
// - second select active high, third active low, sampled with strobes
// - strobe low loads a new address, or deselects when selects inactive
// - advance low continues the burst to the next burst address
// - global write low writes all lanes; otherwise gate and lanes decide
// - gate low with any lane low writes those lanes; none low reads
// - data pins driven only with output enable, chip enabled, read active
// - order select high or floating: interleaved order, start xor count
// - order select low: low address bits count upward and wrap
// - snooze high deselects and idles, keeping stored data
// - in snooze inputs other than rd_ready ignored, data pins high impedance; the mirror buffer still drains
// - snooze input pulled low inside; tie low when unused
// - read data appears on the pins after the edge following the address
// - advance ignored on the processor strobe edge, sampled afterwards
// - controller start needs processor start absent; writes sampled then
// - read output drive lasts two stages after a deselect
`timescale 1ns/1ps
`default_nettype none

module pbs_burst_sram #(
    parameter int ADDR_W = pbs_pkg::ADDR_W_DEF,
    parameter int DATA_W = pbs_pkg::DATA_W_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic master_select_n,
    input wire logic select_high,
    input wire logic select_low_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic [pbs_pkg::LANES-1:0] byte_lane_write_n,
    input wire logic output_enable_n,
    input wire logic burst_order_sel_n,
    input wire logic snooze_req,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic snooze_active,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    import pbs_pkg::*;

    localparam int LANE_W = DATA_W / LANES;
    localparam int WORDS = 2 ** ADDR_W;

    // refuse widths the lane slicing and burst counter cannot serve
    generate
        if (DATA_W % LANES != 0 || DATA_W < LANES) begin : g_bad_data
            $error("data width must split into four equal lanes");
        end
        if (ADDR_W <= BURST_W) begin : g_bad_addr
            $error("address must be wider than the burst field");
        end
    endgenerate

    // asynchronous pins and their synchronisers
    logic snooze_meta;
    logic snooze_sync;
    logic order_meta;
    logic order_sync;

    // access pipeline
    pbs_cyc_t cyc;
    pbs_cyc_t next_cyc;
    logic [ADDR_W-1:0] base_addr;
    logic [ADDR_W-1:0] next_base_addr;
    logic [BURST_W-1:0] burst_start;
    logic [BURST_W-1:0] next_burst_start;
    logic [BURST_W-1:0] burst_cnt;
    logic [BURST_W-1:0] next_burst_cnt;
    logic [ADDR_W-1:0] acc_addr;
    logic [ADDR_W-1:0] cur_addr;
    logic acc_write;

    // decode terms
    logic proc_start;
    logic ctrl_start;
    logic strobe;
    logic chip_sel;
    logic [LANES-1:0] wr_lanes;
    logic wr_cmd;
    logic [BURST_W-1:0] cur_low;
    logic [BURST_W-1:0] step_low;
    logic [BURST_W-1:0] step_cnt;
    logic stall;
    logic run;

    // output register and deselect tail
    logic [DATA_W-1:0] out_data;
    logic out_valid;
    logic dcd_hold;

    // mirror buffer
    logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
    logic buf_wptr;
    logic buf_rptr;
    logic [1:0] buf_cnt;
    logic buf_in_ready;
    logic buf_push;
    logic buf_pop;

    // storage array, not reset so contents survive snooze and reset
    logic [DATA_W-1:0] mem [WORDS];

    // snooze idles low
    // the reset value stands in for the internal pull-down
    // snooze synchroniser
    // the pin is asynchronous, so two flops before any logic looks at it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            snooze_meta <= SNOOZE_SYNC_RST;
            snooze_sync <= SNOOZE_SYNC_RST;
        end else begin
            snooze_meta <= snooze_req;
            snooze_sync <= snooze_meta;
        end
    end

    // static order select, still synchronised in case it moves
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            order_meta <= ORDER_SYNC_RST;
            order_sync <= ORDER_SYNC_RST;
        end else begin
            order_meta <= burst_order_sel_n;
            order_sync <= order_meta;
        end
    end

    assign snooze_active = snooze_sync;

    // master select blocks only the processor strobe
    assign proc_start = !proc_addr_strobe_n && !master_select_n;
    // controller start counts only with processor start absent
    assign ctrl_start = !ctrl_addr_strobe_n && !proc_start;
    assign strobe = proc_start || ctrl_start;
    assign chip_sel = !master_select_n && select_high && !select_low_n;

    always_comb begin
        if (!global_write_n) begin
            wr_lanes = LANES_ALL;
        end else if (!byte_write_gate_n) begin
            wr_lanes = ~byte_lane_write_n;
        end else begin
            wr_lanes = LANES_NONE;
        end
    end
    assign wr_cmd = wr_lanes != LANES_NONE;

    // only the low two bits move
    assign step_cnt = burst_cnt + BURST_STEP;
    assign cur_low = order_sync ? (burst_start ^ burst_cnt)
                                : (burst_start + burst_cnt);
    assign step_low = order_sync ? (burst_start ^ step_cnt)
                                 : (burst_start + step_cnt);
    assign cur_addr = {base_addr[ADDR_W-1:BURST_W], cur_low};

    // a full mirror buffer freezes the core until the result can be kept
    assign stall = (cyc == PBS_CYC_READ) && !buf_in_ready;
    assign run = !snooze_sync && !stall;

    // next access decode for this edge
    always_comb begin
        next_cyc = cyc;
        next_base_addr = base_addr;
        next_burst_start = burst_start;
        next_burst_cnt = burst_cnt;
        acc_addr = cur_addr;
        acc_write = 1'b0;
        if (snooze_sync) begin
            next_cyc = PBS_CYC_IDLE;
        end else if (stall) begin
            next_cyc = cyc;
        end else if (strobe) begin
            if (chip_sel) begin
                // address taken with selects and strobe
                next_base_addr = addr;
                next_burst_start = addr[BURST_W-1:0];
                next_burst_cnt = BURST_ZERO;
                acc_addr = addr;
                if (proc_start) begin
                    // processor start is always a read, lanes ignored
                    next_cyc = PBS_CYC_READ;
                end else begin
                    // write controls sampled on controller edge
                    next_cyc = wr_cmd ? PBS_CYC_WRITE : PBS_CYC_READ;
                    acc_write = wr_cmd;
                end
            end else begin
                next_cyc = PBS_CYC_IDLE;
            end
        end else if (cyc != PBS_CYC_IDLE) begin
            // advance looked at only after the start edge
            if (!burst_advance_n) begin
                next_burst_cnt = step_cnt;
                acc_addr = {base_addr[ADDR_W-1:BURST_W], step_low};
            end else begin
                acc_addr = cur_addr;
            end
            next_cyc = wr_cmd ? PBS_CYC_WRITE : PBS_CYC_READ;
            acc_write = wr_cmd;
        end
    end

    // access state captured on the rising edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cyc <= PBS_CYC_IDLE;
            base_addr <= '0;
            burst_start <= BURST_ZERO;
            burst_cnt <= BURST_ZERO;
        end else begin
            cyc <= next_cyc;
            base_addr <= next_base_addr;
            burst_start <= next_burst_start;
            burst_cnt <= next_burst_cnt;
        end
    end

    // lane writes into the array on the command edge
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < LANES; i++) begin
            if (run && acc_write && wr_lanes[i]) begin
                mem[acc_addr][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
            end
        end
    end

    // read data moves to the output register one edge later
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_data <= '0;
        end else if (run && cyc == PBS_CYC_READ) begin
            out_data <= mem[cur_addr];
        end
    end

    // output drive tail after deselect
    // a write clears both stages at once so the bus turns round quickly
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_valid <= FLAG_RST;
            dcd_hold <= FLAG_RST;
        end else if (snooze_sync || cyc == PBS_CYC_WRITE) begin
            out_valid <= 1'b0;
            dcd_hold <= 1'b0;
        end else if (!stall) begin
            out_valid <= cyc == PBS_CYC_READ;
            dcd_hold <= out_valid;
        end
    end

    assign dq_out = out_data;
    // pins driven only for a read with output enable low
    assign dq_oe = (out_valid || dcd_hold) && !output_enable_n &&
                   !snooze_sync && cyc != PBS_CYC_WRITE;

    // mirror buffer: every read word is also offered on the stream port
    assign buf_in_ready = buf_cnt != 2'(BUF_DEPTH);
    assign buf_push = !snooze_sync && cyc == PBS_CYC_READ && buf_in_ready;
    assign rd_valid = buf_cnt != 2'h0;
    assign buf_pop = rd_valid && rd_ready;
    assign rd_data = buf_mem[buf_rptr];

    // buffer storage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_mem[i] <= '0;
            end
        end else if (buf_push) begin
            buf_mem[buf_wptr] <= mem[cur_addr];
        end
    end

    // buffer pointers and fill count
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            buf_wptr <= 1'b0;
            buf_rptr <= 1'b0;
            buf_cnt <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_wptr <= !buf_wptr;
            end
            if (buf_pop) begin
                buf_rptr <= !buf_rptr;
            end
            if (buf_push && !buf_pop) begin
                buf_cnt <= buf_cnt + 2'h1;
            end else if (buf_pop && !buf_push) begin
                buf_cnt <= buf_cnt - 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> pbs_burst_sram_monitor.sv
// assertion checker on the burst memory control pins
`timescale 1ns/1ps
`default_nettype none
module pbs_burst_sram_monitor #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 36
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic master_select_n,
    input wire logic select_high,
    input wire logic select_low_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic output_enable_n,
    input wire logic snooze_req,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic snooze_active,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic sel_on;
    logic go;
    // selects on; go: pins listened to, sink ready; only an already full buffer stalls
    assign sel_on = !master_select_n && select_high && !select_low_n;
    assign go = !snooze_active && rd_ready;
    property p_snooze_hiz; snooze_active |-> !dq_oe; endproperty
    a_snooze_hiz: assert property (p_snooze_hiz)
        else $error("drive in snooze");
    property p_oe_gate; output_enable_n |-> !dq_oe; endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("drive without enable");
    property p_snooze_in; snooze_req [*3] |-> snooze_active; endproperty
    a_snooze_in: assert property (p_snooze_in)
        else $error("snooze not entered");
    property p_freeze; snooze_active [*3] |-> $stable(dq_out); endproperty
    a_freeze: assert property (p_freeze)
        else $error("output moved in snooze");
    property p_wr_hiz;
        !ctrl_addr_strobe_n && proc_addr_strobe_n && sel_on
            && !global_write_n && go |=> !dq_oe;
    endproperty
    a_wr_hiz: assert property (p_wr_hiz)
        else $error("drive during write");
    property p_rd_drive;
        !proc_addr_strobe_n && sel_on && go
            ##1 go && global_write_n && byte_write_gate_n
            ##1 !output_enable_n && !snooze_active |-> dq_oe;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("read not driven");
    property p_hold;
        rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stalled word lost");
    property p_tail;
        !ctrl_addr_strobe_n && !select_high && go
            ##1 proc_addr_strobe_n && ctrl_addr_strobe_n && rd_ready
            ##1 rd_ready |=> !dq_oe;
    endproperty
    a_tail: assert property (p_tail)
        else $error("drive past deselect");
endmodule
bind pbs_burst_sram pbs_burst_sram_monitor #(.ADDR_W(ADDR_W),
    .DATA_W(DATA_W)) i_pbs_burst_sram_monitor (.*);
`default_nettype wire

// >>> pbs_far_end.sv
// far side: data bus as the master sees it, and the read sink
`timescale 1ns/1ps
`default_nettype none
module pbs_far_end #(
    parameter int DATA_W = 36
) (
    input wire logic sys_clk,
    input wire logic stall,
    input wire logic dq_oe,
    input wire logic [DATA_W-1:0] dq_out,
    output logic rd_ready,
    output logic [DATA_W-1:0] dq_bus
);
    logic [DATA_W-1:0] last;
    // released bus shows the inverse of its last value
    always_ff @(posedge sys_clk) begin
        last <= dq_bus;
    end
    assign dq_bus = dq_oe ? dq_out : ~last;
    // sink stalls only when told to
    assign rd_ready = !stall;
endmodule
`default_nettype wire

// >>> pbs_pkg.sv
// shared constants and types for the pipelined burst memory control block
`default_nettype none

package pbs_pkg;

    // documented organisation: 1M words of 32 or 36 bits in four byte lanes
    localparam int ADDR_W_DEF = 20;
    localparam int DATA_W_DEF = 36;
    localparam int LANES = 4;
    localparam int BURST_W = 2;

    // depth of the read mirror buffer
    localparam int BUF_DEPTH = 2;

    // burst counter values
    localparam logic [1:0] BURST_ZERO = 2'h0;
    localparam logic [1:0] BURST_STEP = 2'h1;

    // lane masks
    localparam logic [3:0] LANES_ALL = 4'hf;
    localparam logic [3:0] LANES_NONE = 4'h0;

    // reset values of the pipeline flags and synchronisers
    localparam logic FLAG_RST = 1'b0;
    localparam logic SNOOZE_SYNC_RST = 1'b0;
    localparam logic ORDER_SYNC_RST = 1'b1;

    // kind of access registered on the last edge
    typedef enum logic [1:0] {
        PBS_CYC_IDLE = 2'b00,
        PBS_CYC_READ = 2'b01,
        PBS_CYC_WRITE = 2'b10
    } pbs_cyc_t;

endpackage

`default_nettype wire

// >>> pipelined_burst_sram_control_tb_top.sv
// self-checking bench for the burst memory control block
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_control_tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] addr;
    logic master_select_n;
    logic select_high;
    logic select_low_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic byte_write_gate_n;
    logic [3:0] byte_lane_write_n;
    logic output_enable_n;
    logic burst_order_sel_n;
    logic snooze_req;
    logic [35:0] dq_in;
    logic [35:0] dq_out;
    logic dq_oe;
    logic snooze_active;
    logic [35:0] rd_data;
    logic rd_valid;
    logic rd_ready;
    logic stall;
    logic [35:0] dq_bus;
    logic [35:0] mem [64];
    int num_errors = 0;
    int num_checks = 0;
    pbs_burst_sram #(.ADDR_W(6)) i_pbs_burst_sram (.*);
    pbs_far_end i_pbs_far_end (.*);
    // 100 MHz
    always #5 sys_clk = ~sys_clk;
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one edge: set at the fall, held over the rise
    task automatic cyc(input logic [2:0] st, input logic [5:0] a,
            input logic [1:0] w, input logic [3:0] ln, input logic [35:0] d);
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = st;
        {global_write_n, byte_write_gate_n} = w;
        {addr, byte_lane_write_n, dq_in} = {a, ln, d};
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [2:0] st, input logic [5:0] a);
        cyc(st, a, 2'b11, 4'hf, 36'h0);
    endtask
    task automatic idle;
        rd(3'b111, 6'h00);
    endtask
    // write via controller strobe; model keeps the lane decode
    // output enable off
    // the caller turns the output enable back on once the writes are done
    task automatic wr(input logic [5:0] a, input logic [1:0] w,
            input logic [3:0] ln, input logic [35:0] d);
        output_enable_n = 1'b1;
        cyc(3'b101, a, w, ln, d);
        for (int i = 0; i < 4; i++) begin
            if (!w[1] || (!w[0] && !ln[i])) begin
                mem[a][i*9 +: 9] = d[i*9 +: 9];
            end
        end
    endtask
    task automatic desel;
        select_high = 1'b0;
        rd(3'b101, 6'h00);
        select_high = 1'b1;
        repeat (3) idle();
    endtask
    task automatic t_write;
        wr(6'h08, 2'b01, 4'h0, 36'h9_1234_5678);
        wr(6'h08, 2'b10, 4'b1110, 36'h0_0000_00a5);
        wr(6'h08, 2'b11, 4'h0, 36'h0);
        wr(6'h08, 2'b10, 4'hf, 36'h0);
        for (int i = 12; i < 16; i++) begin
            wr(6'(i), 2'b01, 4'hf, 36'(i) * 36'h0_0000_1111);
        end
        output_enable_n = 1'b0;
        rd(3'b011, 6'h08);
        idle();
        chk(dq_out, mem[8]);
        chk(dq_bus, mem[8]);
    endtask
    // burst walk, then wrap back to start and suspend
    task automatic burst(input logic [2:0] st, input logic [5:0] a,
            input logic lin);
        logic [1:0] b;
        rd(st, a);
        for (int i = 0; i < 4; i++) begin
            b = lin ? a[1:0] + 2'(i) : a[1:0] ^ 2'(i);
            rd(3'b110, 6'h00);
            chk(dq_out, mem[{a[5:2], b}]);
        end
        idle();
        chk(dq_out, mem[a]);
        idle();
        chk(dq_out, mem[a]);
    endtask
    task automatic t_burst;
        burst(3'b010, 6'h0d, 1'b0);
        burst_order_sel_n = 1'b0;
        repeat (3) idle();
        burst(3'b101, 6'h0e, 1'b1);
    endtask
    // deselect tail, select polarities, processor start ignores writes
    task automatic t_desel;
        select_high = 1'b0;
        rd(3'b101, 6'h00);
        select_high = 1'b1;
        chk(dq_oe, 1'b1);
        idle();
        chk(dq_oe, 1'b1);
        idle();
        chk(dq_oe, 1'b0);
        master_select_n = 1'b1;
        rd(3'b011, 6'h0c);
        master_select_n = 1'b0;
        idle();
        chk(dq_oe, 1'b0);
        select_low_n = 1'b1;
        rd(3'b011, 6'h0c);
        select_low_n = 1'b0;
        idle();
        chk(dq_oe, 1'b0);
        rd(3'b011, 6'h0c);
        idle();
        chk(dq_bus, mem[12]);
        cyc(3'b001, 6'h0d, 2'b01, 4'h0, 36'h0);
        idle();
        chk(dq_out, mem[13]);
        output_enable_n = 1'b1;
        idle();
        chk(dq_oe, 1'b0);
        output_enable_n = 1'b0;
    endtask
    // snooze: ignored write, exit, data kept
    task automatic t_snooze;
        desel();
        snooze_req = 1'b1;
        repeat (3) idle();
        chk(snooze_active, 1'b1);
        cyc(3'b101, 6'h0c, 2'b01, 4'h0, 36'h0);
        repeat (3) idle();
        chk(dq_oe, 1'b0);
        snooze_req = 1'b0;
        repeat (3) idle();
        chk(snooze_active, 1'b0);
        rd(3'b011, 6'h0c);
        idle();
        chk(dq_out, mem[12]);
    endtask
    // two words held by a stalled sink, drained in order
    task automatic t_stream;
        desel();
        stall = 1'b1;
        rd(3'b011, 6'h0c);
        rd(3'b011, 6'h0d);
        desel();
        chk(rd_valid, 1'b1);
        chk(rd_data, mem[12]);
        stall = 1'b0;
        idle();
        chk(rd_data, mem[13]);
        idle();
        chk(rd_valid, 1'b0);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        master_select_n = 1'b0;
        select_high = 1'b1;
        select_low_n = 1'b0;
        output_enable_n = 1'b0;
        burst_order_sel_n = 1'b1;
        snooze_req = 1'b0;
        stall = 1'b0;
        repeat (20) idle();
        rst = 1'b0;
        repeat (2) idle();
        t_write();
        t_burst();
        t_desel();
        t_snooze();
        t_stream();
        end_of_test();
    end
    // hang guard, far past the run length
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
